// [include/vpoc_pkg.sv]
// Constants and types for the picture output control registers
package vpoc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] VPOC_OFF_PIN_CTL = 8'h03;
  localparam logic [7:0] VPOC_OFF_BRIGHT = 8'h09;
  localparam logic [7:0] VPOC_OFF_SAT = 8'h0a;
  localparam logic [7:0] VPOC_OFF_HUE = 8'h0b;
  localparam logic [7:0] VPOC_OFF_CONTRAST = 8'h0c;
  localparam logic [7:0] VPOC_OFF_OUT_FMT = 8'h0d;
  localparam logic [7:0] VPOC_OFF_TRAP = 8'h0e;
  localparam logic [7:0] VPOC_OFF_HSYNC = 8'h16;
  localparam logic [7:0] VPOC_OFF_VBL_START = 8'h18;
  localparam logic [7:0] VPOC_OFF_VBL_END = 8'h19;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] VPOC_RST_BRIGHT = 8'h80;
  localparam logic [7:0] VPOC_RST_SAT = 8'h80;
  localparam logic [7:0] VPOC_RST_HUE = 8'h00;
  localparam logic [7:0] VPOC_RST_CONTRAST = 8'h80;
  localparam logic [7:0] VPOC_RST_OUT_FMT = 8'h40;
  localparam logic [7:0] VPOC_RST_TRAP = 8'h00;
  localparam logic [7:0] VPOC_RST_HSYNC = 8'h80;
  localparam logic [7:0] VPOC_RST_VBL = 8'h00;
  localparam logic [7:0] VPOC_RST_PIN_CTL = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int VPOC_BIT_SAMPLE = 7;
  localparam int VPOC_BIT_RANGE = 6;
  localparam int VPOC_BIT_UVFMT = 5;
  localparam int VPOC_LSB_BYPASS = 3;
  localparam int VPOC_LSB_FMT = 0;
  localparam int VPOC_LSB_PINSEL = 6;
  localparam int VPOC_BIT_VBL_ON = 1;
  localparam logic [7:0] VPOC_MASK_OUT_FMT = 8'hff;
  localparam logic [7:0] VPOC_MASK_TRAP = 8'h03;
  localparam logic [7:0] VPOC_MASK_PIN_CTL = 8'hc2;
  // ----------------------------------------------------------------
  // Code range limits
  // ----------------------------------------------------------------
  localparam logic [7:0] VPOC_STUDIO_MIN = 8'h10;
  localparam logic [7:0] VPOC_STUDIO_Y_MAX = 8'heb;
  localparam logic [7:0] VPOC_STUDIO_C_MAX = 8'hf0;
  localparam logic [7:0] VPOC_EXT_MIN = 8'h01;
  localparam logic [7:0] VPOC_EXT_MAX = 8'hfe;
  // ----------------------------------------------------------------
  // Hsync shift: (centre - setting) * step
  // ----------------------------------------------------------------
  localparam logic signed [10:0] VPOC_HS_CENTRE = 11'sh080;
  localparam int VPOC_HS_STEP_LOG2 = 2;
  // ----------------------------------------------------------------
  // Nominal blank window, in half-line units (line * 2)
  // ----------------------------------------------------------------
  localparam logic [11:0] VPOC_FRAME_525 = 12'h41a;
  localparam logic [11:0] VPOC_FRAME_625 = 12'h4e2;
  localparam logic [11:0] VPOC_NTSC_ODD_S = 12'h002;
  localparam logic [11:0] VPOC_NTSC_ODD_E = 12'h02a;
  localparam logic [11:0] VPOC_NTSC_EVEN_S = 12'h20f;
  localparam logic [11:0] VPOC_NTSC_EVEN_E = 12'h239;
  localparam logic [11:0] VPOC_PAL_ODD_S = 12'h4df;
  localparam logic [11:0] VPOC_PAL_ODD_E = 12'h02f;
  localparam logic [11:0] VPOC_PAL_EVEN_S = 12'h26e;
  localparam logic [11:0] VPOC_PAL_EVEN_E = 12'h29e;
  localparam logic [11:0] VPOC_MPAL_ODD_S = 12'h416;
  localparam logic [11:0] VPOC_MPAL_ODD_E = 12'h02a;
  localparam logic [11:0] VPOC_MPAL_EVEN_S = 12'h209;
  localparam logic [11:0] VPOC_MPAL_EVEN_E = 12'h239;
  localparam logic [11:0] VPOC_FIRST_HALF_LINE = 12'h002;
  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {VPOC_STD_NTSC, VPOC_STD_PAL, VPOC_STD_MPAL, VPOC_STD_COMBN} vpoc_std_t;
  typedef enum logic [1:0] {VPOC_PIN_LOW, VPOC_PIN_HIGH, VPOC_PIN_VBLANK, VPOC_PIN_INPUT} vpoc_pin_t;
endpackage

// [core/vpoc_regs.sv]
// Picture output control register bank with blank window and pin logic
`timescale 1ns/10ps
`default_nettype none
module vpoc_regs
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_host_addr,
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  input wire logic [7:0] i_host_wdata,
  output logic [7:0] o_host_rdata,
  output logic o_host_rvalid,
  input wire logic i_autoswitch_running,
  input wire vpoc_pkg::vpoc_std_t i_std,
  input wire logic i_field_even,
  input wire logic [11:0] i_half_line,
  output logic [7:0] o_brightness,
  output logic [7:0] o_saturation,
  output logic signed [7:0] o_hue,
  output logic [7:0] o_contrast,
  output logic o_square_pixel,
  output logic [7:0] o_luma_min,
  output logic [7:0] o_luma_max,
  output logic [7:0] o_chroma_min,
  output logic [7:0] o_chroma_max,
  output logic o_chroma_twos,
  output logic [1:0] o_bypass_mode,
  output logic [2:0] o_out_format,
  output logic [1:0] o_trap_select,
  output logic signed [10:0] o_hsync_shift,
  output logic o_vertical_blank_window,
  output logic o_general_purpose_ctl_pin,
  output logic o_general_purpose_ctl_pin_oe_n
);
  import vpoc_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] bright_reg, bright_next;
  logic [7:0] sat_reg, sat_next;
  logic [7:0] hue_reg, hue_next;
  logic [7:0] contrast_reg, contrast_next;
  logic [7:0] fmt_reg, fmt_next;
  logic [7:0] trap_reg, trap_next;
  logic [7:0] hsync_reg, hsync_next;
  logic [7:0] vbl_s_reg, vbl_s_next;
  logic [7:0] vbl_e_reg, vbl_e_next;
  logic [7:0] pin_reg, pin_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  // Writes land the cycle after the strobe; reserved trap and pin control bits are cleared
  always_comb
  begin
    bright_next = bright_reg;
    sat_next = sat_reg;
    hue_next = hue_reg;
    contrast_next = contrast_reg;
    fmt_next = fmt_reg;
    trap_next = trap_reg;
    hsync_next = hsync_reg;
    vbl_s_next = vbl_s_reg;
    vbl_e_next = vbl_e_reg;
    pin_next = pin_reg;
    if (i_host_wr)
    begin
      unique case (i_host_addr)
        VPOC_OFF_BRIGHT: bright_next = i_host_wdata;
        VPOC_OFF_SAT: sat_next = i_host_wdata;
        VPOC_OFF_HUE: hue_next = i_host_wdata;
        VPOC_OFF_CONTRAST: contrast_next = i_host_wdata;
        VPOC_OFF_OUT_FMT: fmt_next = i_host_wdata & VPOC_MASK_OUT_FMT;
        VPOC_OFF_TRAP: trap_next = i_host_wdata & VPOC_MASK_TRAP;
        VPOC_OFF_HSYNC: hsync_next = i_host_wdata;
        VPOC_OFF_VBL_START: vbl_s_next = i_host_wdata;
        VPOC_OFF_VBL_END: vbl_e_next = i_host_wdata;
        VPOC_OFF_PIN_CTL: pin_next = i_host_wdata & VPOC_MASK_PIN_CTL;
        default: ;
      endcase
    end
  end

  // Read path: one cycle latency, unmapped offsets read zero
  always_comb
  begin
    rvalid_next = i_host_rd;
    rdata_next = 8'h00;
    if (i_host_rd)
    begin
      unique case (i_host_addr)
        VPOC_OFF_BRIGHT: rdata_next = bright_reg;
        VPOC_OFF_SAT: rdata_next = sat_reg;
        VPOC_OFF_HUE: rdata_next = hue_reg;
        VPOC_OFF_CONTRAST: rdata_next = contrast_reg;
        VPOC_OFF_OUT_FMT: rdata_next = fmt_reg;
        VPOC_OFF_TRAP: rdata_next = trap_reg;
        VPOC_OFF_HSYNC: rdata_next = hsync_reg;
        VPOC_OFF_VBL_START: rdata_next = vbl_s_reg;
        VPOC_OFF_VBL_END: rdata_next = vbl_e_reg;
        VPOC_OFF_PIN_CTL: rdata_next = pin_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Register bank flops
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      bright_reg <= VPOC_RST_BRIGHT;
      sat_reg <= VPOC_RST_SAT;
      hue_reg <= VPOC_RST_HUE;
      contrast_reg <= VPOC_RST_CONTRAST;
      fmt_reg <= VPOC_RST_OUT_FMT;
      trap_reg <= VPOC_RST_TRAP;
      hsync_reg <= VPOC_RST_HSYNC;
      vbl_s_reg <= VPOC_RST_VBL;
      vbl_e_reg <= VPOC_RST_VBL;
      pin_reg <= VPOC_RST_PIN_CTL;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      bright_reg <= bright_next;
      sat_reg <= sat_next;
      hue_reg <= hue_next;
      contrast_reg <= contrast_next;
      fmt_reg <= fmt_next;
      trap_reg <= trap_next;
      hsync_reg <= hsync_next;
      vbl_s_reg <= vbl_s_next;
      vbl_e_reg <= vbl_e_next;
      pin_reg <= pin_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ----------------------------------------------------------------
  // Blank window: nominal edges moved by signed line offsets
  // ----------------------------------------------------------------
  logic [11:0] frame_len;
  logic [11:0] nom_start;
  logic [11:0] nom_end;
  logic [11:0] adj_start;
  logic [11:0] adj_end;
  logic in_window;

  // Wrap an edge into 2..frame+1; offsets are whole lines, so doubled
  function automatic logic [11:0] vpoc_wrap(input logic [11:0] nom, input logic [7:0] off,
                                           input logic [11:0] len);
    logic signed [13:0] sum;
    sum = $signed({2'b00, nom}) + $signed({{5{off[7]}}, off, 1'b0});
    if (sum < $signed({2'b00, VPOC_FIRST_HALF_LINE}))
      sum = sum + $signed({2'b00, len});
    else if (sum >= $signed({2'b00, len}) + $signed({2'b00, VPOC_FIRST_HALF_LINE}))
      sum = sum - $signed({2'b00, len});
    return sum[11:0];
  endfunction

  // Nominal edges per standard and field
  always_comb
  begin
    frame_len = VPOC_FRAME_625;
    nom_start = VPOC_PAL_ODD_S;
    nom_end = VPOC_PAL_ODD_E;
    unique case (i_std)
      VPOC_STD_NTSC:
      begin
        frame_len = VPOC_FRAME_525;
        nom_start = i_field_even ? VPOC_NTSC_EVEN_S : VPOC_NTSC_ODD_S;
        nom_end = i_field_even ? VPOC_NTSC_EVEN_E : VPOC_NTSC_ODD_E;
      end
      VPOC_STD_MPAL:
      begin
        frame_len = VPOC_FRAME_525;
        nom_start = i_field_even ? VPOC_MPAL_EVEN_S : VPOC_MPAL_ODD_S;
        nom_end = i_field_even ? VPOC_MPAL_EVEN_E : VPOC_MPAL_ODD_E;
      end
      VPOC_STD_PAL, VPOC_STD_COMBN:
      begin
        frame_len = VPOC_FRAME_625;
        nom_start = i_field_even ? VPOC_PAL_EVEN_S : VPOC_PAL_ODD_S;
        nom_end = i_field_even ? VPOC_PAL_EVEN_E : VPOC_PAL_ODD_E;
      end
    endcase
  end

  // Window test handles wrap through the frame's first line
  always_comb
  begin
    adj_start = vpoc_wrap(nom_start, vbl_s_reg, frame_len);
    adj_end = vpoc_wrap(nom_end, vbl_e_reg, frame_len);
    if (adj_start <= adj_end)
      in_window = (i_half_line >= adj_start) && (i_half_line <= adj_end);
    else
      in_window = (i_half_line >= adj_start) || (i_half_line <= adj_end);
  end

  // ----------------------------------------------------------------
  // Decoded outputs, all registered
  // ----------------------------------------------------------------
  logic sq_reg, sq_next;
  logic [7:0] y_min_reg, y_min_next;
  logic [7:0] y_max_reg, y_max_next;
  logic [7:0] c_min_reg, c_min_next;
  logic [7:0] c_max_reg, c_max_next;
  logic signed [10:0] hs_reg, hs_next;
  logic win_reg, win_next;
  logic gp_reg, gp_next;
  logic gp_oe_n_reg, gp_oe_n_next;
  vpoc_pin_t pin_sel;

  // Sampling choice is only picked up while the autoswitch routine runs
  always_comb
  begin
    pin_sel = vpoc_pin_t'(pin_reg[VPOC_LSB_PINSEL +: 2]);
    sq_next = i_autoswitch_running ? fmt_reg[VPOC_BIT_SAMPLE] : sq_reg;
    if (fmt_reg[VPOC_BIT_RANGE])
    begin
      y_min_next = VPOC_EXT_MIN;
      y_max_next = VPOC_EXT_MAX;
      c_min_next = VPOC_EXT_MIN;
      c_max_next = VPOC_EXT_MAX;
    end
    else
    begin
      y_min_next = VPOC_STUDIO_MIN;
      y_max_next = VPOC_STUDIO_Y_MAX;
      c_min_next = VPOC_STUDIO_MIN;
      c_max_next = VPOC_STUDIO_C_MAX;
    end
    hs_next = (VPOC_HS_CENTRE - $signed({3'b000, hsync_reg})) <<< VPOC_HS_STEP_LOG2;
    win_next = in_window;
    gp_oe_n_next = 1'b0;
    unique case (pin_sel)
      VPOC_PIN_LOW: gp_next = 1'b0;
      VPOC_PIN_HIGH: gp_next = 1'b1;
      VPOC_PIN_VBLANK: gp_next = in_window & pin_reg[VPOC_BIT_VBL_ON];
      VPOC_PIN_INPUT:
      begin
        gp_next = 1'b0;
        gp_oe_n_next = 1'b1; // Pin is a sync lock input then; release it
      end
    endcase
  end

  // Output flops
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sq_reg <= 1'b0;
      y_min_reg <= VPOC_EXT_MIN;
      y_max_reg <= VPOC_EXT_MAX;
      c_min_reg <= VPOC_EXT_MIN;
      c_max_reg <= VPOC_EXT_MAX;
      hs_reg <= 11'sh000;
      win_reg <= 1'b0;
      gp_reg <= 1'b0;
      gp_oe_n_reg <= 1'b0;
    end
    else
    begin
      sq_reg <= sq_next;
      y_min_reg <= y_min_next;
      y_max_reg <= y_max_next;
      c_min_reg <= c_min_next;
      c_max_reg <= c_max_next;
      hs_reg <= hs_next;
      win_reg <= win_next;
      gp_reg <= gp_next;
      gp_oe_n_reg <= gp_oe_n_next;
    end
  end

  // ----------------------------------------------------------------
  // Port drive
  // ----------------------------------------------------------------
  // Picture, format and trap settings drive the datapath directly; hsync, range and sampling come from the output flops
  assign o_host_rdata = rdata_reg;
  assign o_host_rvalid = rvalid_reg;
  assign o_brightness = bright_reg;
  assign o_saturation = sat_reg;
  assign o_hue = $signed(hue_reg);
  assign o_contrast = contrast_reg;
  assign o_square_pixel = sq_reg;
  assign o_luma_min = y_min_reg;
  assign o_luma_max = y_max_reg;
  assign o_chroma_min = c_min_reg;
  assign o_chroma_max = c_max_reg;
  assign o_chroma_twos = fmt_reg[VPOC_BIT_UVFMT];
  assign o_bypass_mode = fmt_reg[VPOC_LSB_BYPASS +: 2];
  assign o_out_format = fmt_reg[VPOC_LSB_FMT +: 3];
  assign o_trap_select = trap_reg[1:0];
  assign o_hsync_shift = hs_reg;
  assign o_vertical_blank_window = win_reg;
  assign o_general_purpose_ctl_pin = gp_reg;
  assign o_general_purpose_ctl_pin_oe_n = gp_oe_n_reg;
endmodule
`default_nettype wire

// [testbench/vpoc_regs_assertions.sv]
// Assertion checker for the picture output control register bank
`timescale 1ns/10ps
`default_nettype none
module vpoc_chk
  import vpoc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_host_addr,
  input wire logic i_host_wr,
  input wire logic [7:0] i_host_wdata,
  input wire logic i_autoswitch_running,
  input wire logic [7:0] o_brightness,
  input wire logic [7:0] o_saturation,
  input wire logic signed [7:0] o_hue,
  input wire logic [7:0] o_contrast,
  input wire logic o_square_pixel,
  input wire logic [7:0] o_luma_max,
  input wire logic [7:0] o_chroma_max,
  input wire logic o_chroma_twos,
  input wire logic [1:0] o_bypass_mode,
  input wire logic [2:0] o_out_format,
  input wire logic [1:0] o_trap_select,
  input wire logic signed [10:0] o_hsync_shift
);
  // ----
  // Write decodes per register
  // ----
  logic wr_b, wr_s, wr_u, wr_c, wr_f, wr_t, wr_h;
  assign wr_b = i_host_wr && (i_host_addr == VPOC_OFF_BRIGHT);
  assign wr_s = i_host_wr && (i_host_addr == VPOC_OFF_SAT);
  assign wr_u = i_host_wr && (i_host_addr == VPOC_OFF_HUE);
  assign wr_c = i_host_wr && (i_host_addr == VPOC_OFF_CONTRAST);
  assign wr_f = i_host_wr && (i_host_addr == VPOC_OFF_OUT_FMT);
  assign wr_t = i_host_wr && (i_host_addr == VPOC_OFF_TRAP);
  assign wr_h = i_host_wr && (i_host_addr == VPOC_OFF_HSYNC);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Derived outputs lag by two edges, so a repeat write is excluded
  chk_bright_write: assert property (wr_b |=> o_brightness == $past(i_host_wdata))
    else $error("brightness missed a write");
  chk_sat_write: assert property (wr_s |=> o_saturation == $past(i_host_wdata))
    else $error("saturation missed a write");
  chk_hue_write: assert property (wr_u |=> $unsigned(o_hue) == $past(i_host_wdata))
    else $error("hue missed a write");
  chk_contrast_write: assert property (wr_c |=> o_contrast == $past(i_host_wdata))
    else $error("contrast missed a write");
  chk_square_hold: assert property (!i_autoswitch_running [*2] |=> $stable(o_square_pixel))
    else $error("sampling choice moved without autoswitch");
  chk_range_limits: assert property (wr_f ##1 !wr_f |=> o_luma_max ==
    ($past(i_host_wdata[6], 2) ? VPOC_EXT_MAX : VPOC_STUDIO_Y_MAX) && o_chroma_max ==
    ($past(i_host_wdata[6], 2) ? VPOC_EXT_MAX : VPOC_STUDIO_C_MAX))
    else $error("code range limits wrong");
  chk_fmt_fields: assert property (wr_f |=>
    {o_chroma_twos, o_bypass_mode, o_out_format} == $past(i_host_wdata[5:0]))
    else $error("format fields wrong");
  chk_trap_field: assert property (wr_t |=> o_trap_select == $past(i_host_wdata[1:0]))
    else $error("trap select wrong");
  chk_hsync_shift: assert property (wr_h ##1 !wr_h |=> o_hsync_shift ==
    (11'sd128 - $signed({3'b000, $past(i_host_wdata, 2)})) * 11'sd4)
    else $error("hsync shift wrong");
endmodule
bind vpoc_regs vpoc_chk vpoc_chk_i (.i_clk, .i_resetn, .i_host_addr, .i_host_wr,
  .i_host_wdata, .i_autoswitch_running, .o_brightness, .o_saturation, .o_hue,
  .o_contrast, .o_square_pixel, .o_luma_max, .o_chroma_max, .o_chroma_twos,
  .o_bypass_mode, .o_out_format, .o_trap_select, .o_hsync_shift);
`default_nettype wire

// [testbench/vpoc_vid_src.sv]
// Video timing source model: frame-wide half-line count and field flag
`timescale 1ns/10ps
`default_nettype none
module vpoc_vid_src
  import vpoc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_long_frame,
  output logic [11:0] o_half_line,
  output logic o_field_even
);
  logic [11:0] len;
  // Long frames for the 625-line standards, short ones otherwise
  assign len = i_long_frame ? VPOC_FRAME_625 : VPOC_FRAME_525;
  // One half-line per clock keeps a whole frame short
  // Wraps on >= so a switch to short frames mid-frame cannot run away
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_half_line <= VPOC_FIRST_HALF_LINE;
    else if (o_half_line >= len + 12'h001)
      o_half_line <= VPOC_FIRST_HALF_LINE;
    else
      o_half_line <= o_half_line + 12'h001;
  end
  // Second half of the frame is the even field
  assign o_field_even = o_half_line > (len >> 1) + 12'h001;
endmodule
`default_nettype wire

// [testbench/video_picture_output_control_bench.sv]
// Self-checking bench for the picture output control register bank
`timescale 1ns/10ps
`default_nettype none
module video_picture_output_control_bench;
  import vpoc_pkg::*;
  logic clk, resetn, wr, rd, auto, even, rv, sq, twos, win, pin, oe_n;
  logic [7:0] addr, wdata, rdata, bri, sat, con, lmin, lmax, cmin, cmax;
  logic signed [7:0] hue;
  logic signed [10:0] hs;
  logic [1:0] byp, trap;
  logic [2:0] fmt;
  logic [11:0] hl;
  vpoc_std_t std;
  int bad_count, n_checks, base;
  vpoc_vid_src vpoc_vid_src_i (.i_clk(clk), .i_resetn(resetn),
    .i_long_frame(std == VPOC_STD_PAL || std == VPOC_STD_COMBN), .o_half_line(hl),
    .o_field_even(even));
  vpoc_regs vpoc_regs_i (.i_clk(clk), .i_resetn(resetn), .i_host_addr(addr),
    .i_host_wr(wr), .i_host_rd(rd), .i_host_wdata(wdata), .o_host_rdata(rdata),
    .o_host_rvalid(rv), .i_autoswitch_running(auto), .i_std(std),
    .i_field_even(even), .i_half_line(hl), .o_brightness(bri), .o_saturation(sat),
    .o_hue(hue), .o_contrast(con), .o_square_pixel(sq), .o_luma_min(lmin),
    .o_luma_max(lmax), .o_chroma_min(cmin), .o_chroma_max(cmax), .o_chroma_twos(twos),
    .o_bypass_mode(byp), .o_out_format(fmt), .o_trap_select(trap), .o_hsync_shift(hs),
    .o_vertical_blank_window(win), .o_general_purpose_ctl_pin(pin),
    .o_general_purpose_ctl_pin_oe_n(oe_n));
  // ----
  // Shared helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Third edge lets the two-stage derived outputs land
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk({31'h0, rv}, 32'h1);
    chk({24'h0, rdata}, {24'h0, exp});
  endtask
  // A frame's worth of consecutive half-lines visits every half-line once
  task automatic frame_chk(input int len, input int ew, input int ep);
    int nw;
    int np;
    nw = 0;
    np = 0;
    repeat (len)
    begin
      @(negedge clk);
      nw += (win === 1'b1);
      np += (pin === 1'b1);
    end
    chk(nw, ew);
    chk(np, ep);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    chk({bri, sat, con}, 24'h808080);
    chk(hue, 0);
    chk(hs, 0);
    chk({lmin, lmax, cmin, cmax}, 32'h01fe01fe);
    chk({twos, byp, fmt, trap}, 0);
    rd_chk(VPOC_OFF_VBL_START, 8'h00);
    rd_chk(VPOC_OFF_HSYNC, 8'h80);
  endtask
  task automatic t_picture;
    wr_reg(VPOC_OFF_BRIGHT, 8'h8b);
    rd_chk(VPOC_OFF_BRIGHT, 8'h8b);
    wr_reg(VPOC_OFF_SAT, 8'hff);
    chk(sat, 8'hff);
    wr_reg(VPOC_OFF_HUE, 8'h80);
    chk(hue, 32'hffffff80);
    wr_reg(VPOC_OFF_CONTRAST, 8'h00);
    rd_chk(VPOC_OFF_CONTRAST, 8'h00);
    wr_reg(8'h20, 8'h55);
    rd_chk(8'h20, 8'h00);
  endtask
  task automatic t_format;
    logic [7:0] v [6] = '{8'h08, 8'h10, 8'h04, 8'h27, 8'h5b, 8'h40};
    foreach (v[i])
    begin
      wr_reg(VPOC_OFF_OUT_FMT, v[i]);
      chk({twos, byp, fmt}, v[i][5:0]);
      chk({lmin, lmax, cmin, cmax}, v[i][6] ? 32'h01fe01fe : 32'h10eb10f0);
      rd_chk(VPOC_OFF_OUT_FMT, v[i]);
    end
  endtask
  // Sampling choice must not move while the autoswitch routine is idle
  task automatic t_sampling;
    wr_reg(VPOC_OFF_OUT_FMT, 8'hc0);
    chk(sq, 0);
    auto = 1'b1;
    repeat (3) @(negedge clk);
    chk(sq, 1);
    auto = 1'b0;
    wr_reg(VPOC_OFF_OUT_FMT, 8'h40);
    chk(sq, 1);
  endtask
  task automatic t_hsync;
    logic [7:0] v [4] = '{8'h00, 8'hff, 8'h80, 8'h7f};
    int e [4] = '{512, -508, 0, 4};
    foreach (v[i])
    begin
      wr_reg(VPOC_OFF_HSYNC, v[i]);
      chk(32'(hs), e[i]);
    end
  endtask
  task automatic t_trap;
    wr_reg(VPOC_OFF_TRAP, 8'hff);
    rd_chk(VPOC_OFF_TRAP, 8'h03);
    wr_reg(VPOC_OFF_TRAP, 8'h02);
    chk(trap, 2);
  endtask
  // Model splits fields mid-frame, so each window is clipped to its own field
  task automatic t_vblank;
    int mpal;
    int pal;
    base = int'(VPOC_NTSC_ODD_E - VPOC_NTSC_ODD_S) + int'(VPOC_NTSC_EVEN_E - VPOC_NTSC_EVEN_S) + 2;
    mpal = int'(VPOC_MPAL_ODD_E - VPOC_FIRST_HALF_LINE) +
      int'(VPOC_MPAL_EVEN_E - (VPOC_FRAME_525 >> 1));
    pal = int'(VPOC_PAL_ODD_E - VPOC_FIRST_HALF_LINE) +
      int'(VPOC_PAL_EVEN_E - (VPOC_FRAME_625 >> 1));
    wr_reg(VPOC_OFF_PIN_CTL, 8'h82);
    chk(oe_n, 0);
    frame_chk(1050, base, base);
    std = VPOC_STD_MPAL;
    frame_chk(1050, mpal, mpal);
    std = VPOC_STD_PAL;
    frame_chk(1250, pal, pal);
    std = VPOC_STD_COMBN;
    frame_chk(1250, pal, pal);
    std = VPOC_STD_NTSC;
    wr_reg(VPOC_OFF_VBL_START, 8'h05);
    frame_chk(1050, base - 20, base - 20);
    wr_reg(VPOC_OFF_VBL_END, 8'h03);
    frame_chk(1050, base - 8, base - 8);
    wr_reg(VPOC_OFF_PIN_CTL, 8'h80);
    frame_chk(1050, base - 8, 0);
    wr_reg(VPOC_OFF_PIN_CTL, 8'h42);
    frame_chk(1050, base - 8, 1050);
    wr_reg(VPOC_OFF_PIN_CTL, 8'hc2);
    chk(oe_n, 1);
  endtask
  task automatic conclude;
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----
  // Clock and main sequence
  // ----
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    {resetn, wr, rd, auto, addr, wdata} = '0;
    std = VPOC_STD_NTSC;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_picture();
    t_format();
    t_sampling();
    t_hsync();
    t_trap();
    t_vblank();
    conclude();
  end
endmodule
`default_nettype wire
